//--- verilog/pmii_top.sv
// Notes on behaviour
// - Device drives both MII clocks, 25 or 2.5 MHz.
// - Transmit signals are captured on rising clock edge.
// - At 100 Mbps valid spans preamble through data.
// - At 10 Mbps preamble stripped, valid from SFD.
// - Carrier sense is unclocked and follows line reception.
// - Half duplex adds transmit activity to carrier sense.
// - Collision only in half duplex, transmit with receive.
// - Test loopback returns transmit data in full duplex.
// - Operational loopback unless its disable bit is set.
// - Operational loopback only at 10 Mbps half duplex.
`timescale 1ns/10ps
`default_nettype none

module pmii_top #(
    parameter int unsigned REF_HZ = pmii_pkg::LINK_REF_HZ
) (
    // System clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Configuration, system domain.
    input wire logic cfg_spd_100,
    input wire logic cfg_full_dplx,
    input wire logic cfg_test_lpbk,
    input wire logic cfg_op_lpbk_off,
    // Status, system domain.
    output logic stat_tx_act,
    output logic stat_rx_act,
    // Link reference clock.
    input wire logic clk_link,
    // Line receive stream, link domain, one nibble per MII clock.
    input wire logic line_rx_act,
    input wire logic [3:0] line_rx_nib,
    // Line transmit stream, link domain.
    output logic line_tx_en,
    output logic [3:0] line_txd,
    // MII towards the MAC.
    output logic mii_tx_clk,
    output logic mii_rx_clk,
    input wire logic mii_tx_en,
    input wire logic [3:0] mii_txd,
    output logic mii_rx_dv,
    output logic [3:0] mii_rxd,
    output logic mii_crs,
    output logic mii_col
);
    // Receive framing states at 10 Mbps.
    typedef enum logic [1:0] {
        ST_HUNT = 2'b01,
        ST_PASS = 2'b10
    } pmii_rx_e;

    logic [1:0] rst_sync_q; // Reset release synchroniser for the link domain.
    logic link_rst; // Link domain reset.
    logic [3:0] cfg_m_q; // First synchroniser stage, read only by cfg_q.
    logic [3:0] cfg_q; // Configuration in the link domain.
    logic spd_100; // Link at 100 Mbps.
    logic full_dplx; // Link in full duplex.
    logic mii_clk; // Generated MII clock.
    logic tick_rise; // MII rising edge.
    logic tick_fall; // MII falling edge.
    logic tx_en_q; // Sampled transmit enable.
    logic tx_en_d;
    logic [3:0] txd_q; // Sampled transmit nibble.
    logic [3:0] txd_d;
    logic lp_test; // Test loopback in force.
    logic lp_op; // Operational loopback in force.
    logic src_act; // Receive source: active.
    logic [3:0] src_nib; // Receive source: nibble.
    logic stg_act_q; // One nibble of look-ahead.
    logic stg_act_d;
    logic [3:0] stg_nib_q;
    logic [3:0] stg_nib_d;
    logic rx_dv_q; // Outgoing valid.
    logic rx_dv_d;
    logic [3:0] rxd_q; // Outgoing nibble.
    logic [3:0] rxd_d;
    pmii_rx_e st_q; // Framing state.
    pmii_rx_e st_d;
    logic [1:0] sts_m_q; // First status stage, read only by sts_q.
    logic [1:0] sts_q; // Status in the system domain.

    // Hold the link domain in reset until the release has been synchronised.
    always_ff @(posedge clk_link or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync_q <= 2'h3;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b0};
        end
    end
    assign link_rst = rst_sync_q[1];

    // Configuration levels are quasi-static, so two flops per bit suffice.
    always_ff @(posedge clk_link or posedge link_rst) begin
        if (link_rst) begin
            cfg_m_q <= 4'h0;
            cfg_q <= 4'h0;
        end else begin
            cfg_m_q <= {cfg_spd_100, cfg_full_dplx, cfg_test_lpbk, cfg_op_lpbk_off};
            cfg_q <= cfg_m_q;
        end
    end
    assign spd_100 = cfg_q[3];
    assign full_dplx = cfg_q[2];

    // Both MII clocks come from the one divider so they stay in step.
    pmii_clkgen #(
        .REF_HZ(REF_HZ)
    ) u_clkgen (
        .clk_link(clk_link),
        .link_rst(link_rst),
        .spd_100(spd_100),
        .mii_clk(mii_clk),
        .tick_rise(tick_rise),
        .tick_fall(tick_fall)
    );
    assign mii_tx_clk = mii_clk;
    assign mii_rx_clk = mii_clk;

    // Transmit capture at the rising edge; the MAC changes its outputs only
    // after that edge, so the value taken is the one it held across it.
    always_comb begin
        tx_en_d = tx_en_q;
        txd_d = txd_q;
        if (tick_rise) begin
            tx_en_d = mii_tx_en;
            txd_d = mii_txd;
        end
    end

    // Loopback selection. Test loopback wins and cuts off line receive data; carrier sense still follows the line.
    always_comb begin
        lp_test = cfg_q[1] & full_dplx;
        lp_op = ~spd_100 & ~full_dplx & ~cfg_q[0] & tx_en_q;
        if (lp_test | lp_op) begin
            src_act = tx_en_q;
            src_nib = txd_q;
        end else begin
            src_act = line_rx_act;
            src_nib = line_rx_nib;
        end
    end

    // Receive path, advanced at the falling edge so the MAC sees stable data
    // at its rising edge. One nibble of look-ahead lets the 10 Mbps framer see
    // the delimiter's second nibble while its first is still queued.
    always_comb begin
        stg_act_d = stg_act_q;
        stg_nib_d = stg_nib_q;
        rx_dv_d = rx_dv_q;
        rxd_d = rxd_q;
        st_d = st_q;
        if (tick_fall) begin
            stg_act_d = src_act;
            stg_nib_d = src_nib;
            rxd_d = stg_nib_q;
            if (spd_100) begin
                rx_dv_d = stg_act_q;
                st_d = ST_HUNT;
            end else begin
                case (st_q)
                    ST_HUNT: begin
                        // Preamble is dropped until the 5 then D pair turns up.
                        if (stg_act_q && src_act && stg_nib_q == pmii_pkg::SFD_NIB_LO
                                && src_nib == pmii_pkg::SFD_NIB_HI) begin
                            rx_dv_d = 1'b1;
                            st_d = ST_PASS;
                        end else begin
                            rx_dv_d = 1'b0;
                        end
                    end
                    ST_PASS: begin
                        // Valid stays up to the end of the packet.
                        rx_dv_d = stg_act_q;
                        if (!stg_act_q) begin
                            st_d = ST_HUNT;
                        end
                    end
                    default: begin
                        rx_dv_d = 1'b0;
                        st_d = ST_HUNT;
                    end
                endcase
            end
            if (!rx_dv_d) begin
                rxd_d = pmii_pkg::NIB_RST;
            end
        end
    end

    // Link domain registers.
    always_ff @(posedge clk_link or posedge link_rst) begin
        if (link_rst) begin
            tx_en_q <= 1'b0;
            txd_q <= pmii_pkg::NIB_RST;
            stg_act_q <= 1'b0;
            stg_nib_q <= pmii_pkg::NIB_RST;
            rx_dv_q <= 1'b0;
            rxd_q <= pmii_pkg::NIB_RST;
            st_q <= ST_HUNT;
        end else begin
            tx_en_q <= tx_en_d;
            txd_q <= txd_d;
            stg_act_q <= stg_act_d;
            stg_nib_q <= stg_nib_d;
            rx_dv_q <= rx_dv_d;
            rxd_q <= rxd_d;
            st_q <= st_d;
        end
    end

    assign mii_rx_dv = rx_dv_q;
    assign mii_rxd = rxd_q;
    // The line is silent during test loopback.
    assign line_tx_en = tx_en_q & ~lp_test;
    assign line_txd = txd_q;

    // Carrier and collision are plain gates, not tied to any MII clock edge.
    assign mii_crs = line_rx_act | (~full_dplx & tx_en_q);
    assign mii_col = ~full_dplx & tx_en_q & line_rx_act;

    // Activity levels back to the system domain through two flops each.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sts_m_q <= 2'h0;
            sts_q <= 2'h0;
        end else begin
            sts_m_q <= {tx_en_q, stg_act_q};
            sts_q <= sts_m_q;
        end
    end
    assign stat_tx_act = sts_q[1];
    assign stat_rx_act = sts_q[0];
endmodule // pmii_top

`default_nettype wire

//--- verilog/pmii_clkgen.sv
`timescale 1ns/10ps
`default_nettype none
// Shared constants for the MII signalling block.
package pmii_pkg;
    // MII clock rates for each link speed, in hertz.
    localparam int unsigned MII_100_HZ = 25_000_000;
    localparam int unsigned MII_10_HZ = 2_500_000;
    // Default rate of the link reference clock, in hertz.
    localparam int unsigned LINK_REF_HZ = 50_000_000;
    // Width of the half-period counter.
    localparam int CNT_W = 8;
    // Value of every nibble register after reset.
    localparam logic [3:0] NIB_RST = 4'h0;
    // Start-of-frame delimiter nibbles, first then second on the wire.
    localparam logic [3:0] SFD_NIB_LO = 4'h5;
    localparam logic [3:0] SFD_NIB_HI = 4'hD;
    // Depth of every synchroniser.
    localparam int SYNC_STAGES = 2;

    // Half period of the MII clock in reference cycles, never below one.
    function automatic int unsigned half_cnt(input int unsigned ref_hz, input int unsigned mii_hz);
        int unsigned n;
        n = ref_hz / (2 * mii_hz);
        return (n < 1) ? 1 : n;
    endfunction
endpackage

// Divides the link reference clock down to the MII clock rate.
module pmii_clkgen #(
    parameter int unsigned REF_HZ = pmii_pkg::LINK_REF_HZ
) (
    // Link clock and reset.
    input wire logic clk_link,
    input wire logic link_rst,
    // Speed select, one for 100 Mbps.
    input wire logic spd_100,
    // Generated clock and its edge strobes.
    output logic mii_clk,
    output logic tick_rise,
    output logic tick_fall
);
    // Reload values, one half period less one.
    localparam logic [pmii_pkg::CNT_W-1:0] RLD_100 =
        pmii_pkg::CNT_W'(pmii_pkg::half_cnt(REF_HZ, pmii_pkg::MII_100_HZ) - 1);
    localparam logic [pmii_pkg::CNT_W-1:0] RLD_10 =
        pmii_pkg::CNT_W'(pmii_pkg::half_cnt(REF_HZ, pmii_pkg::MII_10_HZ) - 1);

    logic [pmii_pkg::CNT_W-1:0] cnt_q; // Cycles left in this half period.
    logic [pmii_pkg::CNT_W-1:0] cnt_d;
    logic clk_q; // The generated clock level.
    logic clk_d;
    logic wrap; // High on the last cycle of a half period.

    // The speed is only looked at on reload, so a half period is never cut short
    // and no pulse is narrower than half the faster clock's period.
    always_comb begin
        wrap = (cnt_q == '0);
        cnt_d = cnt_q - 1'b1;
        clk_d = clk_q;
        if (wrap) begin
            cnt_d = spd_100 ? RLD_100 : RLD_10;
            clk_d = ~clk_q;
        end
    end

    // Registers only.
    always_ff @(posedge clk_link or posedge link_rst) begin
        if (link_rst) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign mii_clk = clk_q;
    // The strobes mark the reference edge at which the MII clock changes.
    assign tick_rise = wrap & ~clk_q;
    assign tick_fall = wrap & clk_q;
endmodule // pmii_clkgen

`default_nettype wire

//--- verif/pmii_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the MII pins from the link clock domain.
module pmii_checker (
    // Link clock and reset.
    input wire logic clk_link,
    input wire logic sys_rst,
    // Settings.
    input wire logic cfg_spd_100,
    input wire logic cfg_full_dplx,
    // MII and line.
    input wire logic mii_tx_clk,
    input wire logic mii_rx_clk,
    input wire logic mii_tx_en,
    input wire logic mii_rx_dv,
    input wire logic [3:0] mii_rxd,
    input wire logic mii_crs,
    input wire logic mii_col,
    input wire logic line_rx_act,
    input wire logic line_tx_en
);
    default clocking @(posedge clk_link); endclocking
    default disable iff (sys_rst);
    // Cycles each setting has held, so synchroniser delay is waited out.
    logic [3:0] spd_n_q, spd_n_d, dup_n_q, dup_n_d;
    logic spd_q, dup_q;
    // Counts restart on any change and saturate at fifteen.
    always_comb begin
        spd_n_d = (cfg_spd_100 != spd_q) ? 4'h0 : spd_n_q + {3'h0, spd_n_q != 4'hF};
        dup_n_d = (cfg_full_dplx != dup_q) ? 4'h0 : dup_n_q + {3'h0, dup_n_q != 4'hF};
    end
    // Registers only.
    always_ff @(posedge clk_link or posedge sys_rst) begin
        if (sys_rst) begin
            {spd_n_q, dup_n_q, spd_q, dup_q} <= 10'h0;
        end else begin
            {spd_n_q, dup_n_q, spd_q, dup_q} <= {spd_n_d, dup_n_d, cfg_spd_100, cfg_full_dplx};
        end
    end
    clk_pair_a: assert property (mii_tx_clk == mii_rx_clk) else $error("clocks differ");
    clk_fast_a: assert property (spd_n_q == 4'hF && cfg_spd_100 |-> mii_tx_clk != $past(mii_tx_clk))
        else $error("fast clock wrong");
    // With the bench reference a slow half period is six link cycles: the rise
    // is sampled on the first of six high samples, the seventh sample is low.
    clk_slow_a: assert property (spd_n_q == 4'hF && !cfg_spd_100 && $rose(mii_tx_clk)
        |-> mii_tx_clk [*6] ##1 !mii_tx_clk) else $error("slow clock wrong");
    crs_rx_a: assert property (line_rx_act |-> mii_crs) else $error("carrier missing");
    col_need_a: assert property (mii_col |-> line_rx_act) else $error("collision without rx");
    col_full_a: assert property (dup_n_q == 4'hF && cfg_full_dplx |-> !mii_col)
        else $error("collision in full duplex");
    crs_full_a: assert property (dup_n_q == 4'hF && cfg_full_dplx && !line_rx_act |-> !mii_crs)
        else $error("carrier from transmit");
    rx_move_a: assert property (!$stable({mii_rx_dv, mii_rxd}) |-> $fell(mii_rx_clk))
        else $error("rx moved off edge");
    tx_src_a: assert property ($rose(line_tx_en) |-> mii_tx_en || $past(mii_tx_en) || $past(mii_tx_en, 2))
        else $error("line tx without mac");
endmodule // pmii_checker
bind pmii_top pmii_checker u_chk (.*);
`default_nettype wire

//--- verif/pmii_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
// Media access controller transmit side.
module pmii_mac_model (
    // Clock from the block.
    input wire logic mii_tx_clk,
    // Transmit pins.
    output logic mii_tx_en,
    output logic [3:0] mii_txd
);
    initial begin
        mii_tx_en = 1'b0;
        mii_txd = 4'h0;
    end
    // Pins move after falling edges, so they are settled at every rising edge.
    task automatic send(input logic [3:0] q[$]);
        foreach (q[i]) begin
            @(negedge mii_tx_clk);
            mii_tx_en <= 1'b1;
            mii_txd <= q[i];
        end
        @(negedge mii_tx_clk);
        mii_tx_en <= 1'b0;
        mii_txd <= ~mii_txd;
    endtask
endmodule // pmii_mac_model
`default_nettype wire

//--- verif/pmii_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pmii_tb_top;
    logic clk_sys = 1'b0, sys_rst = 1'b1, clk_link = 1'b0, line_rx_act = 1'b0;
    logic cfg_spd_100 = 1'b1, cfg_full_dplx = 1'b1, cfg_test_lpbk = 1'b0, cfg_op_lpbk_off = 1'b0;
    logic stat_tx_act, stat_rx_act, line_tx_en, mii_tx_clk, mii_rx_clk, mii_tx_en, mii_rx_dv, mii_crs, mii_col;
    logic [3:0] line_rx_nib = 4'h0, line_txd, mii_txd, mii_rxd;
    logic [31:0] rng = 32'h5762;
    logic [3:0] got_rx[$], got_tx[$];
    logic crs_seen, col_seen, tx_seen, rx_seen;
    int errors = 0, n_compared = 0, lk = 0;
    initial forever #25 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #16 clk_link = ~clk_link;
    end
    pmii_top #(.REF_HZ(31_250_000)) uut (.*);
    pmii_mac_model mac (.mii_tx_clk(mii_tx_clk), .mii_tx_en(mii_tx_en), .mii_txd(mii_txd));
    // Collect what reaches the MAC and the line, and sticky flags.
    always @(posedge clk_link) lk++;
    always @(posedge mii_rx_clk) if (mii_rx_dv === 1'b1) got_rx.push_back(mii_rxd);
    // The line side moves at the MII rise, so it is taken at the fall where it stands still.
    always @(negedge mii_tx_clk) if (line_tx_en === 1'b1) got_tx.push_back(line_txd);
    always @(negedge clk_link) begin
        crs_seen |= (mii_crs === 1'b1);
        col_seen |= (mii_col === 1'b1);
        tx_seen |= (stat_tx_act === 1'b1);
        rx_seen |= (stat_rx_act === 1'b1);
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_q(input string nm, input logic [3:0] e[$], input logic [3:0] g[$]);
        chk(nm, 16'(e.size()), 16'(g.size()));
        foreach (e[i]) if (i < g.size()) chk(nm, {12'h0, e[i]}, {12'h0, g[i]});
    endtask
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Preamble of several nibbles, the delimiter, then random data.
    task automatic mk(output logic [3:0] q[$]);
        q.delete();
        repeat (3 + rnd() % 4) q.push_back(4'h5);
        q.push_back(4'hD);
        repeat (4 + rnd() % 5) q.push_back(4'(rnd()));
    endtask
    // Line receive stream, moved at rising edges so it is settled when sampled.
    task automatic line_send(input logic [3:0] q[$]);
        foreach (q[i]) begin
            @(posedge mii_rx_clk);
            line_rx_act <= 1'b1;
            line_rx_nib <= q[i];
        end
        @(posedge mii_rx_clk);
        line_rx_act <= 1'b0;
        line_rx_nib <= ~line_rx_nib;
    endtask
    // One setting, one period measurement, then optional frames both ways.
    task automatic run(input logic spd, full, tlb, off, input bit do_tx, do_rx);
        logic [3:0] tx[$], rx[$], ex[$], el[$];
        int t0;
        @(negedge clk_sys);
        {cfg_spd_100, cfg_full_dplx, cfg_test_lpbk, cfg_op_lpbk_off} = {spd, full, tlb, off};
        repeat (40) @(posedge clk_link);
        @(posedge mii_tx_clk);
        t0 = lk;
        @(posedge mii_tx_clk);
        chk("period", spd ? 16'h2 : 16'hC, 16'(lk - t0));
        mk(tx);
        mk(rx);
        got_rx.delete();
        got_tx.delete();
        {crs_seen, col_seen, tx_seen, rx_seen} = 4'h0;
        fork
            if (do_tx) mac.send(tx);
            if (do_rx) line_send(rx);
        join
        repeat (spd ? 12 : 60) @(posedge clk_link);
        if ((tlb && full) || (!spd && !full && !off && do_tx)) ex = tx;
        else if (do_rx) ex = rx;
        // Receive activity follows whatever source feeds the receive side.
        chk("rx act", {15'h0, ex.size() != 0}, {15'h0, rx_seen});
        while (!spd && ex.size() > 1 && !(ex[0] == 4'h5 && ex[1] == 4'hD)) void'(ex.pop_front());
        if (do_tx && !(tlb && full)) el = tx;
        chk_q("rx", ex, got_rx);
        chk_q("line tx", el, got_tx);
        chk("crs", {15'h0, do_rx || (!full && do_tx)}, {15'h0, crs_seen});
        chk("col", {15'h0, !full && do_tx && do_rx}, {15'h0, col_seen});
        chk("tx act", {15'h0, do_tx}, {15'h0, tx_seen});
    endtask
    initial begin
        #2_000_000;
        errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        run(1, 1, 0, 0, 0, 1);
        run(1, 1, 0, 0, 1, 0);
        run(1, 0, 0, 0, 1, 1);
        run(0, 0, 0, 1, 1, 1);
        run(0, 0, 0, 0, 1, 0);
        run(0, 1, 0, 0, 1, 1);
        run(1, 1, 1, 0, 1, 0);
        run(0, 1, 1, 0, 1, 0);
        // Test loopback asked for in half duplex at 100 Mbps is refused.
        run(1, 0, 1, 0, 1, 0);
        test_done();
    end
endmodule // pmii_tb_top
`default_nettype wire
